// ==== inc/sar_adc_pkg.sv ====
package sar_adc_pkg;
  // ---------------------------------------------------------------
  // converter geometry
  // ---------------------------------------------------------------
  localparam int RES_BITS = 10;
  localparam int CHAN_BITS = 5;
  localparam int EXT_CHANNELS = 28;
  localparam logic [4:0] CHAN_TEMP = 5'h1D;
  localparam logic [4:0] CHAN_FVR = 5'h1E;
  // 11.5 bit periods counted in half periods: 1.5 settle, 10 decisions
  localparam logic [4:0] SETTLE_HALVES = 5'h03;
  localparam logic [3:0] TOP_BIT = 4'h9;

  // ---------------------------------------------------------------
  // register word offsets (byte address bits 4:2)
  // ---------------------------------------------------------------
  localparam logic [2:0] OFS_CTRL_FIRST = 3'h0;
  localparam logic [2:0] OFS_CTRL_SECOND = 3'h1;
  localparam logic [2:0] OFS_RESULT_HIGH = 3'h2;
  localparam logic [2:0] OFS_RESULT_LOW = 3'h3;
  localparam logic [2:0] OFS_FLAG = 3'h4;
  localparam logic [2:0] OFS_ENABLE = 3'h5;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int F_ENABLE = 0;
  localparam int F_GO = 1;
  localparam int F_CHAN_LO = 2;
  localparam int F_PREF_LO = 0;
  localparam int F_CSEL_LO = 4;
  localparam int F_FMT = 7;
  localparam int F_DONE = 0;
  localparam int F_IRQEN = 0;

  // ---------------------------------------------------------------
  // clock select encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] CSEL_RC = 2'h3;
  localparam int DIV_BITS = 6;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] RST_CODE = 10'h000;
endpackage

// ==== inc/sar_ctrl_if.sv ====
`timescale 1ns/1ns
interface sar_ctrl_if;
  logic start;
  logic stop;
  logic kill;
  logic restart;
  logic [2:0] clockSelect;
  logic frcLevel;
  logic halfTick;
  logic compBit;
  logic busy;
  logic sampling;
  logic completed;
  logic storeRes;
  logic [9:0] result;
  logic [9:0] trialCode;

  modport ctrl (
    output start, stop, kill, restart, clockSelect, frcLevel, compBit,
    input halfTick, busy, sampling, completed, storeRes, result, trialCode
  );
  modport div (
    input restart, clockSelect, frcLevel,
    output halfTick
  );
  modport seq (
    input start, stop, kill, halfTick, compBit,
    output busy, sampling, completed, storeRes, result, trialCode
  );
endinterface

// ==== tb/sar_adc_control_assertions.sv ====
`timescale 1ns/1ns
module sar_adc_control_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // power and front end
  input wire logic sleepIn,
  input wire logic irqReq,
  input wire logic wakeReq,
  input wire logic [4:0] muxChannel,
  input wire logic tempSelect,
  input wire logic fvrSelect,
  input wire logic [1:0] refSelect,
  input wire logic analogOn,
  input wire logic sampleHold
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ------
  // shadows of software state
  // ------
  logic acc;
  logic wr;
  logic [2:0] word;
  logic goSh_ff, flagSh_ff, irqEnSh_ff;
  logic [2:0] cselSh_ff;
  logic [7:0] holdCnt_ff;
  assign acc = wb_cyc_i & wb_stb_i & wb_ack_o;
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign word = wb_adr_i[4:2];
  // stale shadows only switch checks off, never on
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      goSh_ff <= 1'b0;
      flagSh_ff <= 1'b0;
      irqEnSh_ff <= 1'b0;
      cselSh_ff <= 3'h0;
      holdCnt_ff <= 8'h00;
    end else begin
      holdCnt_ff <= sampleHold ? holdCnt_ff + 8'h01 : 8'h00;
      if (acc && !wb_we_i && word == 3'h0) goSh_ff <= wb_dat_o[1];
      if (acc && !wb_we_i && word == 3'h4) flagSh_ff <= wb_dat_o[0];
      if (wr && word == 3'h0) goSh_ff <= wb_dat_i[1];
      if (wr && word == 3'h1) cselSh_ff <= wb_dat_i[6:4];
      if (wr && word == 3'h4) flagSh_ff <= 1'b0;
      if (wr && word == 3'h5) irqEnSh_ff <= wb_dat_i[0];
    end
  end
  // ------
  // properties
  // ------
  property p_start;
    wr && word == 3'h0 && wb_dat_i[1:0] == 2'b11 && !goSh_ff && !sleepIn |-> ##[1:4] sampleHold;
  endproperty
  a_start: assert property (p_start) else $error("no sample phase after start");
  property p_flag_kept;
    acc && !wb_we_i && word == 3'h4 && flagSh_ff |-> wb_dat_o[0];
  endproperty
  a_flag_kept: assert property (p_flag_kept) else $error("done flag lost");
  property p_irq;
    flagSh_ff && irqEnSh_ff |-> irqReq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request missing");
  property p_irq_mask;
    !irqEnSh_ff |-> !irqReq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt raised");
  property p_wake;
    wakeReq == (sleepIn && irqReq);
  endproperty
  a_wake: assert property (p_wake) else $error("wake request wrong");
  property p_sleep_off;
    sleepIn && cselSh_ff[1:0] != 2'b11 |-> ##[0:2] !analogOn;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("converter on in sleep");
  property p_ref;
    wr && word == 3'h1 |=> refSelect == $past(wb_dat_i[1:0]);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong");
  property p_chan;
    wr && word == 3'h0 |=> muxChannel == $past(wb_dat_i[6:2]);
  endproperty
  a_chan: assert property (p_chan) else $error("channel select wrong");
  property p_special;
    tempSelect == (muxChannel == sar_adc_pkg::CHAN_TEMP)
      && fvrSelect == (muxChannel == sar_adc_pkg::CHAN_FVR);
  endproperty
  a_special: assert property (p_special) else $error("special channel decode");
  // three half periods plus the cycle in which the divider restarts
  property p_settle;
    $fell(sampleHold) && cselSh_ff[1:0] != 2'b11 && analogOn
      |-> holdCnt_ff == (8'h03 << {cselSh_ff[1:0], cselSh_ff[2]}) + 8'h01;
  endproperty
  a_settle: assert property (p_settle) else $error("settle length wrong");
  c_start: cover property ($rose(sampleHold));
  c_wake: cover property (wakeReq);
  c_flag: cover property (acc && !wb_we_i && word == 3'h4 && wb_dat_o[0]);
endmodule // sar_adc_control_assertions

bind sar_adc_control sar_adc_control_assertions chk (.*);

// ==== tb/sar_front_end_model.sv ====
`timescale 1ns/1ns
module sar_front_end_model #(
  parameter int FRC_HALF_NS = 790
) (
  // clock
  input wire logic clk_sys,
  // analog stimulus and converter state
  input wire logic [9:0] level,
  input wire logic [4:0] muxChannel,
  input wire logic [9:0] trialCode,
  input wire logic analogOn,
  // comparator and oscillator
  output logic compIn,
  output logic frcClkIn
);
  logic [9:0] vin;
  logic junk = 1'b0;
  // each channel sees its own level, so a wrong route shows in the code
  assign vin = level + {5'h00, muxChannel};
  // powered-down comparator output is meaningless: keep it moving
  always @(posedge clk_sys) junk <= ~junk;
  assign compIn = analogOn ? (vin >= trialCode) : junk;
  // dedicated oscillator runs free, also in sleep; one process drives it
  initial begin
    frcClkIn = 1'b0;
    forever #(FRC_HALF_NS) frcClkIn = ~frcClkIn;
  end
endmodule // sar_front_end_model

// ==== tb/test_sar_adc_control.sv ====
`timescale 1ns/1ns
module test_sar_adc_control;
  localparam int LIMIT = 40000;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0000_0000;
  logic sleepIn = 1'b0;
  logic [9:0] level = 10'h000;
  logic [31:0] seed = 32'h0000_d47b;
  logic [31:0] rd;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irqReq, wakeReq, compIn, frcClkIn;
  logic tempSelect, fvrSelect, analogOn, sampleHold;
  logic [4:0] muxChannel;
  logic [1:0] refSelect;
  logic [9:0] trialCode;
  int badCount = 0;
  int nCompared = 0;
  int cycles = 0;
  always #20 clk_sys = ~clk_sys;
  sar_adc_control dut (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sleepIn(sleepIn), .irqReq(irqReq), .wakeReq(wakeReq),
    .compIn(compIn), .frcClkIn(frcClkIn), .muxChannel(muxChannel), .tempSelect(tempSelect),
    .fvrSelect(fvrSelect), .refSelect(refSelect), .analogOn(analogOn),
    .sampleHold(sampleHold), .trialCode(trialCode));
  sar_front_end_model afe (.clk_sys(clk_sys), .level(level), .muxChannel(muxChannel),
    .trialCode(trialCode), .analogOn(analogOn), .compIn(compIn), .frcClkIn(frcClkIn));
  // ------
  // helpers
  // ------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] fmt(input logic [9:0] r, input logic right);
    return right ? {6'h00, r} : {r, 6'h00};
  endfunction
  task automatic closeOut;
    $display("counts: %0d compared, %0d unexpected", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic fail(input string m);
    badCount++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string m);
    nCompared++;
    if (got !== exp) fail($sformatf("%s got %h want %h", m, got, exp));
  endtask
  task automatic chkBit(input logic got, input logic exp, input string m);
    chkWord({31'h0, got}, {31'h0, exp}, m);
  endtask
  // one classic cycle; held until ack is seen high at a rising edge
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) fail("no acknowledge");
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic start(input logic [4:0] ch);
    bus(5'h00, 1'b1, {1'b0, ch, 2'b01});
    bus(5'h00, 1'b1, {1'b0, ch, 2'b11});
  endtask
  task automatic convert(input logic [4:0] ch);
    int n;
    n = 0;
    start(ch);
    do begin
      bus(5'h00, 1'b0, 8'h00);
      n++;
    end while (rd[1] !== 1'b0 && n < 500);
    if (n >= 500) fail("conversion hangs");
  endtask
  task automatic chkResult(input logic [9:0] code, input logic right);
    logic [15:0] e;
    e = fmt(code, right);
    bus(5'h08, 1'b0, 8'h00);
    chkWord(rd, {24'h00_0000, e[15:8]}, "result high");
    bus(5'h0c, 1'b0, 8'h00);
    chkWord(rd, {24'h00_0000, e[7:0]}, "result low");
  endtask
  task automatic chkFlag(input logic exp);
    bus(5'h10, 1'b0, 8'h00);
    chkWord(rd, {31'h0, exp}, "done flag");
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail("run too long");
      closeOut();
    end
  end
  // ------
  // main sequence
  // ------
  initial begin
    logic [7:0] cfg;
    logic [4:0] ch;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      bus(5'(i * 4), 1'b0, 8'h00);
      chkWord(rd, 32'h0000_0000, "reset or unmapped value");
    end
    bus(5'h18, 1'b1, 8'hff);
    bus(5'h18, 1'b0, 8'h00);
    chkWord(rd, 32'h0000_0000, "unmapped write");
    $display("test reset values done");
    // every clock code, incl. both rc codes; fast dividers checked for timing only
    for (int s = 0; s < 8; s++) begin
      seed = lfsr(seed);
      ch = 5'(seed[4:0] % 28);
      cfg = {seed[7], 3'(s), 2'b00, seed[9:8]};
      @(posedge clk_sys) level <= seed[19:10] & 10'h3df;
      bus(5'h10, 1'b1, 8'h00);
      bus(5'h04, 1'b1, cfg);
      @(negedge clk_sys);
      chkWord({30'h0, refSelect}, {30'h0, cfg[1:0]}, "reference");
      convert(ch);
      chkWord({27'h0, muxChannel}, {27'h0, ch}, "channel");
      if (cfg[5:4] != 2'b00) chkResult(level + {5'h00, ch}, cfg[7]);
      chkFlag(1'b1);
      $display("test clock code %0d done", s);
    end
    repeat (200) @(posedge clk_sys);
    chkFlag(1'b1);
    bus(5'h14, 1'b1, 8'h01);
    @(negedge clk_sys);
    chkBit(irqReq, 1'b1, "irq set");
    bus(5'h14, 1'b1, 8'h00);
    @(negedge clk_sys);
    chkBit(irqReq, 1'b0, "irq masked");
    bus(5'h10, 1'b1, 8'h00);
    chkFlag(1'b0);
    $display("test flag and interrupt done");
    // settling waits are the software's duty
    bus(5'h04, 1'b1, 8'ha0);
    bus(5'h00, 1'b1, {1'b0, 5'h1e, 2'b01});
    @(negedge clk_sys);
    chkBit(fvrSelect, 1'b1, "reference channel");
    bus(5'h00, 1'b1, {1'b0, 5'h1d, 2'b01});
    @(negedge clk_sys);
    chkBit(tempSelect, 1'b1, "temperature channel");
    repeat (5000) @(posedge clk_sys);
    convert(5'h1d);
    chkResult(level + 10'h01d, 1'b1);
    repeat (5000) @(posedge clk_sys);
    convert(5'h1d);
    chkResult(level + 10'h01d, 1'b1);
    $display("test temperature channel done");
    // abort after two to four decisions: the tail copies the last decided one
    bus(5'h10, 1'b1, 8'h00);
    @(posedge clk_sys) level <= 10'h3c0;
    start(5'h00);
    repeat (155) @(posedge clk_sys);
    bus(5'h00, 1'b1, 8'h01);
    chkResult(10'h3ff, 1'b1);
    chkFlag(1'b0);
    $display("test abort done");
    start(5'h00);
    repeat (60) @(posedge clk_sys);
    sleepIn <= 1'b1;
    repeat (4) @(negedge clk_sys);
    chkBit(analogOn, 1'b0, "off in sleep");
    @(posedge clk_sys) sleepIn <= 1'b0;
    bus(5'h00, 1'b0, 8'h00);
    chkWord(rd, 32'h0000_0001, "go cleared, enable kept");
    $display("test sleep abort done");
    bus(5'h14, 1'b1, 8'h01);
    bus(5'h04, 1'b1, 8'hb0);
    start(5'h02);
    sleepIn <= 1'b1;
    for (int n = 0; n < 2000 && wakeReq !== 1'b1; n++) @(negedge clk_sys);
    chkBit(wakeReq, 1'b1, "wake");
    @(posedge clk_sys) sleepIn <= 1'b0;
    chkResult(level + 10'h002, 1'b1);
    bus(5'h10, 1'b1, 8'h00);
    bus(5'h00, 1'b1, 8'h02);
    repeat (10) @(negedge clk_sys);
    chkBit(sampleHold, 1'b0, "go without enable");
    bus(5'h00, 1'b0, 8'h00);
    chkWord(rd, 32'h0000_0000, "go ignored");
    $display("test sleep wake done");
    closeOut();
  end
endmodule // test_sar_adc_control

// ==== verilog/conv_clock_div.sv ====
`timescale 1ns/1ns
module conv_clock_div (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // control and tick
  sar_ctrl_if.div ifc
);
  typedef struct packed {
    logic [sar_adc_pkg::DIV_BITS-1:0] cnt;
    logic frcPrev;
    logic tick;
  } div_state_t;

  div_state_t cur, nxt_cur;
  logic [sar_adc_pkg::DIV_BITS-1:0] halfLast;

  // half bit period is 2^k system cycles, k packed as {sel1, sel0, sel2}
  assign halfLast = sar_adc_pkg::DIV_BITS'((1 << {ifc.clockSelect[1:0], ifc.clockSelect[2]}) - 1);
  assign ifc.halfTick = cur.tick;

  always_comb begin
    nxt_cur = cur;
    nxt_cur.tick = 1'b0;
    nxt_cur.frcPrev = ifc.frcLevel;
    if (ifc.restart) begin
      nxt_cur.cnt = '0;
    end else if (ifc.clockSelect[1:0] == sar_adc_pkg::CSEL_RC) begin
      // both rc edges mark half bit periods
      nxt_cur.tick = ifc.frcLevel != cur.frcPrev;
    end else if (cur.cnt >= halfLast) begin
      nxt_cur.cnt = '0;
      nxt_cur.tick = 1'b1;
    end else begin
      nxt_cur.cnt = cur.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= nxt_cur;
    end
  end
endmodule // conv_clock_div

// ==== verilog/sar_adc_control.sv ====
`timescale 1ns/1ns

// Operation
// - successive approximation yields 10-bit stored result
// - thirty channels: external, temperature, reference
// - channel field routes input to sample-hold
// - one channel code reserved for temperature
// - reference field picks reference pin or supply
// - clock field sets divider or rc oscillator
// - conversion lasts 11.5 bit periods
// - only rc clock keeps converter running asleep
// - done flag set on every completion
// - enabled completion interrupt wakes sleeping device
// - format bit left or right justifies result
// - completion clears go, flags, loads result
// - early go clear stores padded partial result
// - sleep on system clock aborts, enable kept
module sar_adc_control (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // device power and interrupt
  input wire logic sleepIn,
  output logic irqReq,
  output logic wakeReq,
  // analog front end
  input wire logic compIn,
  input wire logic frcClkIn,
  output logic [4:0] muxChannel,
  output logic tempSelect,
  output logic fvrSelect,
  output logic [1:0] refSelect,
  output logic analogOn,
  output logic sampleHold,
  output logic [9:0] trialCode
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [7:0] rdat;
    logic enable;
    logic go;
    logic [4:0] chan;
    logic fmt;
    logic [2:0] clkSel;
    logic [1:0] pref;
    logic [7:0] resHigh;
    logic [7:0] resLow;
    logic doneFlag;
    logic irqEn;
    logic [1:0] compSync;
    logic [1:0] frcSync;
    logic sample;
    logic [9:0] trial;
    logic startPend;
  } ctl_state_t;

  ctl_state_t cur, nxt_cur;
  sar_ctrl_if ifc ();

  logic access;
  logic writeNow;
  logic [2:0] wordIdx;
  logic rcSelected;
  logic sleepAbort;
  logic [7:0] readMux;
  logic [7:0] wrByte;
  logic [7:0] fmtHigh;
  logic [7:0] fmtLow;

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  conv_clock_div u_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ifc(ifc.div)
  );

  sar_sequencer u_seq (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ifc(ifc.seq)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign access = wb_cyc_i && wb_stb_i;
  // the write lands on the edge where ack is seen, as the master expects
  assign writeNow = access && wb_we_i && cur.ack && wb_sel_i[0];
  assign wordIdx = wb_adr_i[4:2];
  assign wrByte = wb_dat_i[7:0];
  assign wb_ack_o = cur.ack;
  assign wb_dat_o = {24'h00_0000, cur.rdat};

  // ---------------------------------------------------------------
  // conversion clock and sleep
  // ---------------------------------------------------------------
  assign rcSelected = cur.clkSel[1:0] == sar_adc_pkg::CSEL_RC;
  // a system-derived clock stops in sleep, so the work is lost
  assign sleepAbort = sleepIn && !rcSelected;

  // ---------------------------------------------------------------
  // result formatting
  // ---------------------------------------------------------------
  always_comb begin
    if (cur.fmt) begin
      // right justified: top two bits in the high byte
      fmtHigh = {6'h00, ifc.result[9:8]};
      fmtLow = ifc.result[7:0];
    end else begin
      fmtHigh = ifc.result[9:2];
      fmtLow = {ifc.result[1:0], 6'h00};
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    readMux = sar_adc_pkg::RST_BYTE;
    case (wordIdx)
      sar_adc_pkg::OFS_CTRL_FIRST: begin
        readMux[sar_adc_pkg::F_ENABLE] = cur.enable;
        readMux[sar_adc_pkg::F_GO] = cur.go;
        readMux[sar_adc_pkg::F_CHAN_LO +: 5] = cur.chan;
      end
      sar_adc_pkg::OFS_CTRL_SECOND: begin
        readMux[sar_adc_pkg::F_PREF_LO +: 2] = cur.pref;
        readMux[sar_adc_pkg::F_CSEL_LO +: 3] = cur.clkSel;
        readMux[sar_adc_pkg::F_FMT] = cur.fmt;
      end
      sar_adc_pkg::OFS_RESULT_HIGH: begin
        readMux = cur.resHigh;
      end
      sar_adc_pkg::OFS_RESULT_LOW: begin
        readMux = cur.resLow;
      end
      sar_adc_pkg::OFS_FLAG: begin
        readMux[sar_adc_pkg::F_DONE] = cur.doneFlag;
      end
      sar_adc_pkg::OFS_ENABLE: begin
        readMux[sar_adc_pkg::F_IRQEN] = cur.irqEn;
      end
      default: begin
        readMux = sar_adc_pkg::RST_BYTE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer control
  // ---------------------------------------------------------------
  always_comb begin
    ifc.clockSelect = cur.clkSel;
    ifc.frcLevel = cur.frcSync[1];
    ifc.compBit = cur.compSync[1];
    ifc.start = cur.startPend && cur.enable && !sleepAbort;
    ifc.restart = ifc.start;
    ifc.kill = !cur.enable || sleepAbort;
    // software dropping go mid-conversion keeps a partial answer
    ifc.stop = writeNow && wordIdx == sar_adc_pkg::OFS_CTRL_FIRST
      && !wrByte[sar_adc_pkg::F_GO] && ifc.busy;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_cur = cur;
    nxt_cur.ack = access && !cur.ack;
    nxt_cur.rdat = readMux;
    nxt_cur.compSync = {cur.compSync[0], compIn};
    nxt_cur.frcSync = {cur.frcSync[0], frcClkIn};
    nxt_cur.startPend = 1'b0;
    nxt_cur.sample = ifc.sampling;
    nxt_cur.trial = ifc.trialCode;

    if (writeNow) begin
      case (wordIdx)
        sar_adc_pkg::OFS_CTRL_FIRST: begin
          nxt_cur.enable = wrByte[sar_adc_pkg::F_ENABLE];
          nxt_cur.chan = wrByte[sar_adc_pkg::F_CHAN_LO +: 5];
          if (wrByte[sar_adc_pkg::F_GO] && !cur.go && wrByte[sar_adc_pkg::F_ENABLE]) begin
            nxt_cur.go = 1'b1;
            nxt_cur.startPend = 1'b1;
          end else if (!wrByte[sar_adc_pkg::F_GO]) begin
            nxt_cur.go = 1'b0;
          end
        end
        sar_adc_pkg::OFS_CTRL_SECOND: begin
          nxt_cur.pref = wrByte[sar_adc_pkg::F_PREF_LO +: 2];
          nxt_cur.clkSel = wrByte[sar_adc_pkg::F_CSEL_LO +: 3];
          nxt_cur.fmt = wrByte[sar_adc_pkg::F_FMT];
        end
        sar_adc_pkg::OFS_FLAG: begin
          // software writes the bit either way, so a 1 sets it; the hardware set below wins
          nxt_cur.doneFlag = wrByte[sar_adc_pkg::F_DONE];
        end
        sar_adc_pkg::OFS_ENABLE: begin
          nxt_cur.irqEn = wrByte[sar_adc_pkg::F_IRQEN];
        end
        default: begin
          nxt_cur.enable = cur.enable;
        end
      endcase
    end

    // abort in sleep or on disable: go drops, enable stays as written
    if (sleepAbort && cur.go) begin
      nxt_cur.go = 1'b0;
    end
    if (!nxt_cur.enable) begin
      nxt_cur.go = 1'b0;
    end

    if (ifc.storeRes) begin
      nxt_cur.resHigh = fmtHigh;
      nxt_cur.resLow = fmtLow;
    end
    if (ifc.completed) begin
      nxt_cur.go = 1'b0;
      nxt_cur.doneFlag = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= nxt_cur;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign muxChannel = cur.chan;
  assign tempSelect = cur.chan == sar_adc_pkg::CHAN_TEMP;
  assign fvrSelect = cur.chan == sar_adc_pkg::CHAN_FVR;
  assign refSelect = cur.pref;
  // in sleep the analog side stays up only on rc and only while useful
  assign analogOn = cur.enable && !sleepAbort
    && !(sleepIn && !cur.go && !cur.irqEn);
  assign sampleHold = cur.sample;
  assign trialCode = cur.trial;
  assign irqReq = cur.doneFlag && cur.irqEn;
  assign wakeReq = sleepIn && cur.doneFlag && cur.irqEn;

endmodule // sar_adc_control

// ==== verilog/sar_sequencer.sv ====
`timescale 1ns/1ns
module sar_sequencer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // control
  sar_ctrl_if.seq ifc
);
  typedef enum logic [1:0] {IDLE, SETTLE, DECIDE} phase_t;

  typedef struct packed {
    phase_t phase;
    logic [4:0] halves;
    logic oddHalf;
    logic [3:0] bitIdx;
    logic [9:0] code;
    logic lastBit;
    logic completed;
    logic storeRes;
    logic [9:0] result;
  } seq_state_t;

  seq_state_t cur, nxt_cur;
  logic [9:0] decided;
  logic [9:0] partial;

  assign ifc.busy = cur.phase != IDLE;
  assign ifc.sampling = cur.phase == SETTLE;
  assign ifc.completed = cur.completed;
  assign ifc.storeRes = cur.storeRes;
  assign ifc.result = cur.result;
  assign ifc.trialCode = cur.code;

  always_comb begin
    decided = cur.code;
    decided[cur.bitIdx] = ifc.compBit;
    // undecided bits copy the last decision
    partial = cur.code;
    for (int i = 0; i < sar_adc_pkg::RES_BITS; i++) begin
      if (cur.phase != DECIDE || i <= int'(cur.bitIdx)) begin
        partial[i] = cur.lastBit;
      end
    end
  end

  always_comb begin
    nxt_cur = cur;
    nxt_cur.completed = 1'b0;
    nxt_cur.storeRes = 1'b0;
    if (ifc.kill) begin
      nxt_cur.phase = IDLE;
    end else if (ifc.stop && cur.phase != IDLE) begin
      nxt_cur.phase = IDLE;
      nxt_cur.result = partial;
      nxt_cur.storeRes = 1'b1;
    end else begin
      case (cur.phase)
        IDLE: begin
          if (ifc.start) begin
            nxt_cur.phase = SETTLE;
            nxt_cur.halves = '0;
            nxt_cur.lastBit = 1'b0;
            nxt_cur.code = sar_adc_pkg::RST_CODE;
          end
        end
        SETTLE: begin
          if (ifc.halfTick) begin
            nxt_cur.halves = cur.halves + 1'b1;
            if (cur.halves + 1'b1 == sar_adc_pkg::SETTLE_HALVES) begin
              nxt_cur.phase = DECIDE;
              nxt_cur.oddHalf = 1'b0;
              nxt_cur.bitIdx = sar_adc_pkg::TOP_BIT;
              nxt_cur.code = sar_adc_pkg::RST_CODE;
              nxt_cur.code[sar_adc_pkg::TOP_BIT] = 1'b1;
            end
          end
        end
        DECIDE: begin
          if (ifc.halfTick) begin
            nxt_cur.oddHalf = !cur.oddHalf;
            if (cur.oddHalf) begin
              // one decision per bit period
              nxt_cur.code = decided;
              nxt_cur.lastBit = ifc.compBit;
              if (cur.bitIdx == '0) begin
                nxt_cur.phase = IDLE;
                nxt_cur.result = decided;
                nxt_cur.storeRes = 1'b1;
                nxt_cur.completed = 1'b1;
              end else begin
                nxt_cur.bitIdx = cur.bitIdx - 1'b1;
                nxt_cur.code[cur.bitIdx - 1'b1] = 1'b1;
              end
            end
          end
        end
        default: begin
          nxt_cur.phase = IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= nxt_cur;
    end
  end
endmodule // sar_sequencer
